// ===== rtl/lcsc_pkg.sv
package lcsc_pkg;
   // Register offsets
   localparam logic [7:0] MODE_OFFSET     = 8'h01;
   localparam logic [7:0] LEVEL1_OFFSET   = 8'h02;
   localparam logic [7:0] LEVEL2_OFFSET   = 8'h03;
   localparam logic [7:0] LEVEL3_OFFSET   = 8'h04;
   localparam logic [7:0] LEVEL4_OFFSET   = 8'h05;
   localparam logic [7:0] STATUS_OFFSET   = 8'h2b;
   // Reset values
   localparam logic [7:0] MODE_RESET      = 8'h03;
   localparam logic [7:0] LEVEL1_RESET    = 8'h40;
   localparam logic [7:0] LEVEL_RESET     = 8'h00;
   localparam logic [3:0] STATUS_RESET    = 4'h0;
   // Field layout
   localparam int         MODE_FIELD_W    = 2;
   localparam int         CHANNELS        = 4;
   // Drive modes
   typedef enum logic [1:0] {
      LCSC_MODE_OFF     = 2'b00,
      LCSC_MODE_ON      = 2'b01,
      LCSC_MODE_PWM     = 2'b10,
      LCSC_MODE_PATTERN = 2'b11
   } lcsc_mode_t;
endpackage : lcsc_pkg

// ===== rtl/lcsc_regs.sv
`timescale 1ns/1ps
module lcsc_regs (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   // Analog side
   input  wire logic [3:0]  source_below_200mv,
   input  wire logic        pwm_gate,
   input  wire logic        pattern_gate,
   input  wire logic        pump_automatic_enable,
   output logic      [3:0]  source_enable,
   output logic      [31:0] source_level,
   output logic             pump_start
);

   typedef struct packed {
      logic [7:0]  mode;
      logic [31:0] level;
      logic [3:0]  flags;
      logic [3:0]  enable;
      logic [31:0] drive;
      logic        pump;
      logic [7:0]  rdata;
      logic        rvalid;
   } lcsc_state_t;

   lcsc_state_t st;
   lcsc_state_t next_st;
   lcsc_pkg::lcsc_mode_t m;

   always_comb begin
      next_st = st;
      m       = lcsc_pkg::LCSC_MODE_OFF;
      if (reg_wr) begin
         case (reg_addr)
            lcsc_pkg::MODE_OFFSET:   next_st.mode = reg_wdata;
            lcsc_pkg::LEVEL1_OFFSET: next_st.level[7:0] = reg_wdata;
            lcsc_pkg::LEVEL2_OFFSET: next_st.level[15:8] = reg_wdata;
            lcsc_pkg::LEVEL3_OFFSET: next_st.level[23:16] = reg_wdata;
            lcsc_pkg::LEVEL4_OFFSET: next_st.level[31:24] = reg_wdata;
            default: ; // Status and unmapped writes dropped
         endcase
      end
      next_st.flags = source_below_200mv;
      for (int i = 0; i < lcsc_pkg::CHANNELS; i++) begin
         m = lcsc_pkg::lcsc_mode_t'(st.mode[i*lcsc_pkg::MODE_FIELD_W +: lcsc_pkg::MODE_FIELD_W]);
         case (m)
            lcsc_pkg::LCSC_MODE_OFF:     next_st.enable[i] = 1'b0;
            lcsc_pkg::LCSC_MODE_ON:      next_st.enable[i] = 1'b1;
            lcsc_pkg::LCSC_MODE_PWM:     next_st.enable[i] = pwm_gate;
            lcsc_pkg::LCSC_MODE_PATTERN: next_st.enable[i] = pattern_gate;
            default:                     next_st.enable[i] = 1'b0;
         endcase
         next_st.drive[i*8 +: 8] = (m == lcsc_pkg::LCSC_MODE_OFF) ? 8'h00
                                   : st.level[i*8 +: 8];
      end
      next_st.pump = pump_automatic_enable && (|st.enable) && (|st.flags);
      next_st.rvalid = reg_rd;
      next_st.rdata  = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            lcsc_pkg::MODE_OFFSET:   next_st.rdata = st.mode;
            lcsc_pkg::LEVEL1_OFFSET: next_st.rdata = st.level[7:0];
            lcsc_pkg::LEVEL2_OFFSET: next_st.rdata = st.level[15:8];
            lcsc_pkg::LEVEL3_OFFSET: next_st.rdata = st.level[23:16];
            lcsc_pkg::LEVEL4_OFFSET: next_st.rdata = st.level[31:24];
            lcsc_pkg::STATUS_OFFSET: next_st.rdata = {4'h0, st.flags};
            default:                 next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st        <= '0;
         st.mode   <= lcsc_pkg::MODE_RESET;
         st.level  <= {lcsc_pkg::LEVEL_RESET, lcsc_pkg::LEVEL_RESET,
                       lcsc_pkg::LEVEL_RESET, lcsc_pkg::LEVEL1_RESET};
         st.flags  <= lcsc_pkg::STATUS_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata     = st.rdata;
   assign reg_rvalid    = st.rvalid;
   assign source_enable = st.enable;
   assign source_level  = st.drive;
   assign pump_start    = st.pump;

   // Checks
   property p_flag_track;
      @(posedge ref_clk) disable iff (rst)
      ##1 st.flags == $past(source_below_200mv);
   endproperty
   a_flag_track: assert property (p_flag_track) else $error("flag mismatch");

   property p_status_read;
      @(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr == lcsc_pkg::STATUS_OFFSET) |=>
         reg_rvalid && reg_rdata == {4'h0, $past(st.flags)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_status_wr;
      @(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == lcsc_pkg::STATUS_OFFSET) |=>
         st.mode == $past(st.mode) && st.level == $past(st.level);
   endproperty
   a_status_wr: assert property (p_status_wr) else $error("status write had effect");

   property p_off_zero;
      @(posedge ref_clk) disable iff (rst)
      (st.mode[1:0] == 2'b00) |=> source_level[7:0] == 8'h00 && !source_enable[0];
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("off source driven");

   property p_on_mode;
      @(posedge ref_clk) disable iff (rst)
      (st.mode[7:6] == 2'b01) |=> source_enable[3] && source_level[31:24] == $past(st.level[31:24]);
   endproperty
   a_on_mode: assert property (p_on_mode) else $error("on mode not driven");

   property p_mode_write;
      @(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == lcsc_pkg::MODE_OFFSET) |=> st.mode == $past(reg_wdata);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write lost");

   property p_level_write;
      @(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == lcsc_pkg::LEVEL3_OFFSET) |=> st.level[23:16] == $past(reg_wdata);
   endproperty
   a_level_write: assert property (p_level_write) else $error("level write lost");

   sequence s_pump_cond;
      pump_automatic_enable && (|st.enable) && (|st.flags);
   endsequence
   property p_pump;
      @(posedge ref_clk) disable iff (rst)
      s_pump_cond |=> pump_start;
   endproperty
   a_pump: assert property (p_pump) else $error("pump not started");

   property p_pwm;
      @(posedge ref_clk) disable iff (rst)
      (st.mode[3:2] == 2'b10) |=> source_enable[1] == $past(pwm_gate);
   endproperty
   a_pwm: assert property (p_pwm) else $error("pwm gating wrong");

   // Register access steps
   sequence s_wr(logic [7:0] addr);
      reg_wr && reg_addr == addr;
   endsequence
   sequence s_rd(logic [7:0] addr);
      reg_rd && reg_addr == addr;
   endsequence

   property p_reset_state;
      @(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> st.mode == lcsc_pkg::MODE_RESET && st.flags == lcsc_pkg::STATUS_RESET
         && st.level == {lcsc_pkg::LEVEL_RESET, lcsc_pkg::LEVEL_RESET,
                         lcsc_pkg::LEVEL_RESET, lcsc_pkg::LEVEL1_RESET};
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state");

   property p_reset_outputs;
      @(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> !reg_rvalid && reg_rdata == 8'h00 && source_enable == 4'h0
         && source_level == 32'h0 && !pump_start;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("reset outputs wrong");

   property p_reset_drive;
      @(posedge ref_clk) disable iff (rst)
      $fell(rst) |=> source_level == {24'h000000, lcsc_pkg::LEVEL1_RESET};
   endproperty
   a_reset_drive: assert property (p_reset_drive) else $error("reset drive wrong");

   property p_level1_path;
      @(posedge ref_clk) disable iff (rst)
      s_wr(lcsc_pkg::LEVEL1_OFFSET) ##1 (st.mode[1:0] != 2'b00)
         |=> source_level[7:0] == $past(reg_wdata, 2);
   endproperty
   a_level1_path: assert property (p_level1_path) else $error("level one drive lost");

   property p_level2_path;
      @(posedge ref_clk) disable iff (rst)
      s_wr(lcsc_pkg::LEVEL2_OFFSET) ##1 (st.mode[3:2] != 2'b00)
         |=> source_level[15:8] == $past(reg_wdata, 2);
   endproperty
   a_level2_path: assert property (p_level2_path) else $error("level two drive lost");

   property p_level3_path;
      @(posedge ref_clk) disable iff (rst)
      s_wr(lcsc_pkg::LEVEL3_OFFSET) ##1 (st.mode[5:4] != 2'b00)
         |=> source_level[23:16] == $past(reg_wdata, 2);
   endproperty
   a_level3_path: assert property (p_level3_path) else $error("level three drive lost");

   property p_level4_path;
      @(posedge ref_clk) disable iff (rst)
      s_wr(lcsc_pkg::LEVEL4_OFFSET) ##1 (st.mode[7:6] != 2'b00)
         |=> source_level[31:24] == $past(reg_wdata, 2);
   endproperty
   a_level4_path: assert property (p_level4_path) else $error("level four drive lost");

   property p_level1_write;
      @(posedge ref_clk) disable iff (rst)
      s_wr(lcsc_pkg::LEVEL1_OFFSET) |=> st.level[7:0] == $past(reg_wdata);
   endproperty
   a_level1_write: assert property (p_level1_write) else $error("level one write lost");

   property p_level2_write;
      @(posedge ref_clk) disable iff (rst)
      s_wr(lcsc_pkg::LEVEL2_OFFSET) |=> st.level[15:8] == $past(reg_wdata);
   endproperty
   a_level2_write: assert property (p_level2_write) else $error("level two write lost");

   property p_level4_write;
      @(posedge ref_clk) disable iff (rst)
      s_wr(lcsc_pkg::LEVEL4_OFFSET) |=> st.level[31:24] == $past(reg_wdata);
   endproperty
   a_level4_write: assert property (p_level4_write) else $error("level four write lost");

   property p_mode_read;
      @(posedge ref_clk) disable iff (rst)
      s_rd(lcsc_pkg::MODE_OFFSET) |=> reg_rvalid && reg_rdata == $past(st.mode);
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

   property p_level1_read;
      @(posedge ref_clk) disable iff (rst)
      s_rd(lcsc_pkg::LEVEL1_OFFSET) |=> reg_rvalid && reg_rdata == $past(st.level[7:0]);
   endproperty
   a_level1_read: assert property (p_level1_read) else $error("level one read wrong");

   property p_level3_read;
      @(posedge ref_clk) disable iff (rst)
      s_rd(lcsc_pkg::LEVEL3_OFFSET) |=> reg_rvalid && reg_rdata == $past(st.level[23:16]);
   endproperty
   a_level3_read: assert property (p_level3_read) else $error("level three read wrong");

   property p_pattern_one;
      @(posedge ref_clk) disable iff (rst)
      (st.mode[1:0] == 2'b11) |=> source_enable[0] == $past(pattern_gate)
         && source_level[7:0] == $past(st.level[7:0]);
   endproperty
   a_pattern_one: assert property (p_pattern_one) else $error("pattern gating wrong");

   property p_on_two;
      @(posedge ref_clk) disable iff (rst)
      (st.mode[3:2] == 2'b01) |=> source_enable[1]
         && source_level[15:8] == $past(st.level[15:8]);
   endproperty
   a_on_two: assert property (p_on_two) else $error("source two not on");

   property p_on_three;
      @(posedge ref_clk) disable iff (rst)
      (st.mode[5:4] == 2'b01) |=> source_enable[2]
         && source_level[23:16] == $past(st.level[23:16]);
   endproperty
   a_on_three: assert property (p_on_three) else $error("source three not on");

   property p_off_two;
      @(posedge ref_clk) disable iff (rst)
      (st.mode[3:2] == 2'b00) |=> source_level[15:8] == 8'h00 && !source_enable[1];
   endproperty
   a_off_two: assert property (p_off_two) else $error("source two driven");

   property p_off_three;
      @(posedge ref_clk) disable iff (rst)
      (st.mode[5:4] == 2'b00) |=> source_level[23:16] == 8'h00 && !source_enable[2];
   endproperty
   a_off_three: assert property (p_off_three) else $error("source three driven");

   property p_off_four;
      @(posedge ref_clk) disable iff (rst)
      (st.mode[7:6] == 2'b00) |=> source_level[31:24] == 8'h00 && !source_enable[3];
   endproperty
   a_off_four: assert property (p_off_four) else $error("source four driven");

   property p_pump_manual;
      @(posedge ref_clk) disable iff (rst)
      !pump_automatic_enable |=> !pump_start;
   endproperty
   a_pump_manual: assert property (p_pump_manual) else $error("pump without auto mode");

   property p_pump_no_low;
      @(posedge ref_clk) disable iff (rst)
      !(|st.flags) |=> !pump_start;
   endproperty
   a_pump_no_low: assert property (p_pump_no_low) else $error("pump without low source");

   property p_pump_no_source;
      @(posedge ref_clk) disable iff (rst)
      !(|st.enable) |=> !pump_start;
   endproperty
   a_pump_no_source: assert property (p_pump_no_source) else $error("pump with sources off");

   property p_status_flags_kept;
      @(posedge ref_clk) disable iff (rst)
      s_wr(lcsc_pkg::STATUS_OFFSET) |=> st.flags == $past(source_below_200mv);
   endproperty
   a_status_flags_kept: assert property (p_status_flags_kept) else $error("flags hit");

endmodule : lcsc_regs

// ===== dv/test_led_current_source_control.sv
`timescale 1ns/1ps
module test_led_current_source_control;
   // Bench drive and observe
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic [3:0]  low_hr = 4'h0;
   logic        pwm_gate = 1'b0;
   logic        pattern_gate = 1'b1;
   logic        pump_auto = 1'b0;
   logic [7:0]  reg_rdata;
   logic        reg_rvalid;
   logic [3:0]  source_enable;
   logic [31:0] source_level;
   logic        pump_start;
   int          n_fail = 0;
   int          samples_checked = 0;

   always #10 ref_clk = ~ref_clk;

   lcsc_regs u_dut (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .source_below_200mv(low_hr), .pwm_gate(pwm_gate),
      .pattern_gate(pattern_gate), .pump_automatic_enable(pump_auto),
      .source_enable(source_enable), .source_level(source_level), .pump_start(pump_start));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("rvalid %h", a), 32'h1, {31'h0, reg_rvalid});
      chk($sformatf("rdata %h", a), {24'h0, exp}, {24'h0, reg_rdata});
   endtask : rd

   task automatic settle();
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   initial begin
      repeat (2000) @(posedge ref_clk);
      n_fail++;
      test_done();
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      settle();
      chk("enable", 32'h1, {28'h0, source_enable});
      chk("level", 32'h40, source_level);
      rd(8'h01, 8'h03);
      rd(8'h02, 8'h40);
      for (int i = 3; i <= 5; i++) rd(8'(i), 8'h00);
      rd(8'h2b, 8'h00);
      // Four off, three on, two PWM, one pattern
      wr(8'h01, 8'h1b);
      wr(8'h02, 8'hff);
      wr(8'h03, 8'h01);
      wr(8'h04, 8'h80);
      wr(8'h05, 8'h7e);
      rd(8'h01, 8'h1b);
      rd(8'h02, 8'hff);
      rd(8'h05, 8'h7e);
      settle();
      chk("enable", 32'h5, {28'h0, source_enable});
      chk("level", 32'h008001ff, source_level);
      @(posedge ref_clk);
      pwm_gate     <= 1'b1;
      pattern_gate <= 1'b0;
      settle();
      chk("enable", 32'h6, {28'h0, source_enable});
      wr(8'h01, 8'h40);
      wr(8'h05, 8'h3c);
      settle();
      chk("enable", 32'h8, {28'h0, source_enable});
      chk("level", 32'h3c000000, source_level);
      wr(8'h01, 8'h00);
      settle();
      chk("enable", 32'h0, {28'h0, source_enable});
      chk("level", 32'h0, source_level);
      @(posedge ref_clk);
      low_hr    <= 4'ha;
      pump_auto <= 1'b1;
      settle();
      rd(8'h2b, 8'h0a);
      chk("pump", 32'h0, {31'h0, pump_start});
      wr(8'h2b, 8'hff);
      rd(8'h2b, 8'h0a);
      wr(8'h10, 8'h55);
      rd(8'h10, 8'h00);
      wr(8'h01, 8'h04);
      settle();
      chk("pump", 32'h1, {31'h0, pump_start});
      @(posedge ref_clk);
      low_hr <= 4'h0;
      settle();
      chk("pump", 32'h0, {31'h0, pump_start});
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd(8'h01, 8'h03);
      chk("level", 32'h40, source_level);
      test_done();
   end
endmodule : test_led_current_source_control
